// ### asc_device.sv
// converter end of the serial command port: frame receiver, command decoder,
// configuration word, result shifter and break-before-make input selection.
// assumes link pins are asynchronous and result_i holds the oldest result.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// R1 - break-before-make selection of inputs or test levels
// R2 - config bit 7 takes minus input away
// R3 - sixteen bits, msb first, command then data
// R4 - padding bits ignored for dataless commands
// R5 - readback: four dummies then config word
// R6 - result in top ten bits, six dummies
// R7 - straight binary: low ref 000h, top 3FFh
// R8 - twos complement: low ref 200h, top 1FFh
// R9 - sync high at select fall: rise samples
// R10 - sync fall starts frame: fall samples
// R11 - host writes zero config after power-up
// R12 - codes 0-7 channels; four-input part even only
// R13 - code 8 powers analog and reference down
// R14 - code 9 returns config in low bits
// R15 - code A loads twelve data bits
// R16 - codes B, C, D pick test levels
// R17 - code E shifts oldest fifo entry out
// R18 - code F does nothing
// R19 - sampling starts after select command decoded
// R20 - shifted result is previous conversion
// R21 - output released outside frame, after bit 16
// R22 - config bit 10 picks output coding
module asc_device #(
   parameter bit EIGHT_INPUTS = 1'b1
) (
   input  wire logic                          sys_clk_i,
   input  wire logic                          reset_i,
   asc_link_if.dev                            link,
   input  wire logic [asc_pkg::RES_BITS-1:0] result_i,
   output logic      [3:0]                   mux_sel_o,
   output logic                              mux_en_o,
   output logic                              sample_start_o,
   output logic                              power_down_o,
   output logic                              pseudo_diff_o,
   output logic                              fifo_pop_o,
   output logic      [asc_pkg::CFG_BITS-1:0] config_word_o
);
   typedef enum logic [1:0] {F_IDLE, F_WAIT_SYNC, F_SHIFT} asc_frame_t;
   typedef enum logic [1:0] {M_ON, M_BREAK, M_MAKE} asc_mux_t;

   logic [1:0]  sclk_sy;
   logic [1:0]  cs_sy;
   logic [1:0]  fsync_sy;
   logic [1:0]  sdi_sy;
   logic        sclk_d;
   logic        cs_d;
   logic        fsync_d;
   asc_frame_t  frame_state;
   asc_mux_t    mux_state;
   logic        sync_mode;
   logic [4:0]  in_cnt;
   logic [4:0]  out_cnt;
   logic [15:0] shift_in;
   logic [15:0] next_shift;
   logic [15:0] out_word;
   logic [3:0]  command_nibble;
   logic [11:0] config_word;
   logic [3:0]  pend_sel;
   logic [9:0]  res_fmt;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        cs_fall;
   logic        fsync_fall;
   logic        lead;
   logic        trail;
   logic        start;
   logic        cmd_stb;
   logic        end_stb;
   logic        sel_ok;
   logic [3:0]  sel_val;

   // pin synchronisers
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         sclk_sy  <= 2'h0;
         cs_sy    <= 2'h3;
         fsync_sy <= 2'h3;
         sdi_sy   <= 2'h0;
         sclk_d   <= 1'b0;
         cs_d     <= 1'b1;
         fsync_d  <= 1'b1;
      end else begin
         sclk_sy  <= {sclk_sy[0], link.sclk};
         cs_sy    <= {cs_sy[0], link.cs_n};
         fsync_sy <= {fsync_sy[0], link.frame_sync_in};
         sdi_sy   <= {sdi_sy[0], link.sdi};
         sclk_d   <= sclk_sy[1];
         cs_d     <= cs_sy[1];
         fsync_d  <= fsync_sy[1];
      end
   end

   assign sclk_rise  = sclk_sy[1] & ~sclk_d;
   assign sclk_fall  = ~sclk_sy[1] & sclk_d;
   assign cs_fall    = cs_d & ~cs_sy[1];
   assign fsync_fall = fsync_d & ~fsync_sy[1];
   assign lead  = sync_mode ? sclk_fall : sclk_rise; // see R9 see R10
   assign trail = sync_mode ? sclk_rise : sclk_fall; // see R9 see R10
   assign next_shift = {shift_in[14:0], sdi_sy[1]}; // see R3

   assign start = ((frame_state == F_IDLE) && cs_fall && fsync_sy[1])   // see R9
      || ((frame_state == F_WAIT_SYNC) && fsync_fall && !cs_sy[1]);      // see R10
   assign cmd_stb = (frame_state == F_SHIFT) && lead && !cs_sy[1]
      && (in_cnt == asc_pkg::CNT_CMD);
   assign end_stb = (frame_state == F_SHIFT) && lead && !cs_sy[1]
      && (in_cnt == asc_pkg::CNT_LAST);

   // output coding of the previous result
   assign res_fmt = config_word[asc_pkg::CFG_TWOS_BIT]                  // see R22
      ? {~result_i[asc_pkg::RES_BITS-1], result_i[asc_pkg::RES_BITS-2:0]} // see R8
      : result_i;                                                         // see R7

   // frame receiver and result shifter
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         frame_state <= F_IDLE;
         sync_mode   <= 1'b0;
         in_cnt      <= 5'h00;
         out_cnt     <= 5'h00;
         shift_in    <= 16'h0000;
         out_word    <= 16'h0000;
         link.sdo    <= 1'b0;
         link.sdo_oe <= 1'b0;
      end else if (cs_sy[1]) begin
         frame_state <= F_IDLE;
         link.sdo_oe <= 1'b0; // see R21
      end else begin
         case (frame_state)
            F_IDLE: begin
               if (cs_fall && !fsync_sy[1]) begin
                  sync_mode   <= 1'b1;
                  frame_state <= F_WAIT_SYNC;
               end else if (start) begin
                  sync_mode <= 1'b0;
               end
            end
            F_WAIT_SYNC: ;
            F_SHIFT: begin
               if (lead && in_cnt != asc_pkg::CNT_FULL) begin
                  shift_in <= next_shift;
                  in_cnt   <= in_cnt + 5'h01;
               end
               if (cmd_stb && next_shift[3:0] == asc_pkg::CMD_READ_CFG) begin
                  out_word[asc_pkg::CFG_BITS-1:0] <= config_word; // see R5 see R14
               end
               if (trail && in_cnt > out_cnt) begin
                  out_cnt <= out_cnt + 5'h01;
                  if (out_cnt == asc_pkg::CNT_LAST) begin
                     link.sdo_oe <= 1'b0; // see R21
                     frame_state <= F_IDLE;
                  end else begin
                     link.sdo <= out_word[asc_pkg::TOP_NEXT - out_cnt[3:0]];
                  end
               end
            end
            default: frame_state <= F_IDLE;
         endcase
         if (start) begin
            frame_state <= F_SHIFT;
            in_cnt      <= 5'h00;
            out_cnt     <= 5'h00;
            out_word    <= {res_fmt, {asc_pkg::PAD_BITS{1'b0}}}; // see R6 see R17 see R20
            link.sdo    <= res_fmt[asc_pkg::RES_BITS-1];
            link.sdo_oe <= 1'b1;
         end
      end
   end

   // command register and configuration word
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         command_nibble <= asc_pkg::CMD_RESERVED;
         config_word    <= asc_pkg::CFG_RESET;
      end else begin
         if (cmd_stb) begin
            command_nibble <= next_shift[3:0]; // see R3
         end
         if (end_stb && command_nibble == asc_pkg::CMD_WRITE_CFG) begin
            config_word <= next_shift[asc_pkg::CFG_BITS-1:0]; // see R15 see R11
         end
      end
   end

   // selection decode; data bits play no part here
   always_comb begin
      sel_ok  = 1'b0;
      sel_val = 4'h0;
      if (next_shift[3:0] <= asc_pkg::CMD_LAST_CHAN) begin // see R4
         if (EIGHT_INPUTS) begin
            sel_val = next_shift[3:0];
            sel_ok  = !(config_word[asc_pkg::CFG_PDIFF_BIT]
                        && sel_val == asc_pkg::MINUS_CHAN_8); // see R2
         end else begin
            sel_val = {1'b0, next_shift[3:1]};
            sel_ok  = !next_shift[0]                          // see R12
               && !(config_word[asc_pkg::CFG_PDIFF_BIT]
                    && sel_val == asc_pkg::MINUS_CHAN_4);     // see R2
         end
      end else begin
         case (next_shift[3:0])
            asc_pkg::CMD_TEST_MID: begin
               sel_ok  = 1'b1;
               sel_val = asc_pkg::SEL_TEST_MID; // see R16
            end
            asc_pkg::CMD_TEST_LOW: begin
               sel_ok  = 1'b1;
               sel_val = asc_pkg::SEL_TEST_LOW;
            end
            asc_pkg::CMD_TEST_HIGH: begin
               sel_ok  = 1'b1;
               sel_val = asc_pkg::SEL_TEST_HIGH;
            end
            default: sel_ok = 1'b0; // see R18
         endcase
      end
   end

   // multiplexer: open old path, switch, then close new one
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         mux_state      <= M_ON;
         mux_sel_o      <= 4'h0;
         mux_en_o       <= 1'b0;
         pend_sel       <= 4'h0;
         sample_start_o <= 1'b0;
      end else begin
         sample_start_o <= 1'b0;
         case (mux_state)
            M_ON: begin
               if (cmd_stb && sel_ok) begin
                  pend_sel  <= sel_val;
                  mux_en_o  <= 1'b0; // see R1
                  mux_state <= M_BREAK;
               end
            end
            M_BREAK: begin
               mux_sel_o <= pend_sel; // see R12 see R16
               mux_state <= M_MAKE;
            end
            M_MAKE: begin
               mux_en_o       <= 1'b1; // see R1
               sample_start_o <= 1'b1; // see R19
               mux_state      <= M_ON;
            end
            default: mux_state <= M_ON;
         endcase
      end
   end

   // power-down, fifo pop and configuration outputs
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         power_down_o  <= 1'b0;
         fifo_pop_o    <= 1'b0;
         pseudo_diff_o <= 1'b0;
         config_word_o <= asc_pkg::CFG_RESET;
      end else begin
         if (cmd_stb && next_shift[3:0] == asc_pkg::CMD_POWER_DOWN) begin
            power_down_o <= 1'b1; // see R13
         end else if (start) begin
            power_down_o <= 1'b0;
         end
         fifo_pop_o    <= end_stb && command_nibble == asc_pkg::CMD_FIFO_READ; // see R17
         pseudo_diff_o <= config_word[asc_pkg::CFG_PDIFF_BIT]; // see R2
         config_word_o <= config_word;
      end
   end
endmodule // asc_device
`default_nettype wire

// ### asc_pkg.sv
// shared constants of the serial command port: frame layout, command codes,
// multiplexer selections, configuration fields and serial clock timing.
// assumes both ends run on one 50 MHz system clock.
package asc_pkg;
   localparam int FRAME_BITS = 16;
   localparam int RES_BITS   = 10;
   localparam int CFG_BITS   = 12;
   localparam int PAD_BITS   = 6;

   // bit counters inside a frame
   localparam logic [4:0] CNT_CMD  = 5'h03;
   localparam logic [4:0] CNT_LAST = 5'h0f;
   localparam logic [4:0] CNT_FULL = 5'h10;
   localparam logic [3:0] TOP_NEXT = 4'he;

   // command codes
   localparam logic [3:0] CMD_LAST_CHAN  = 4'h7;
   localparam logic [3:0] CMD_POWER_DOWN = 4'h8;
   localparam logic [3:0] CMD_READ_CFG   = 4'h9;
   localparam logic [3:0] CMD_WRITE_CFG  = 4'ha;
   localparam logic [3:0] CMD_TEST_MID   = 4'hb;
   localparam logic [3:0] CMD_TEST_LOW   = 4'hc;
   localparam logic [3:0] CMD_TEST_HIGH  = 4'hd;
   localparam logic [3:0] CMD_FIFO_READ  = 4'he;
   localparam logic [3:0] CMD_RESERVED   = 4'hf;

   // multiplexer selections: 0..7 analog inputs, then test levels
   localparam logic [3:0] SEL_TEST_MID  = 4'h8;
   localparam logic [3:0] SEL_TEST_LOW  = 4'h9;
   localparam logic [3:0] SEL_TEST_HIGH = 4'ha;
   localparam logic [3:0] MINUS_CHAN_8  = 4'h2;
   localparam logic [3:0] MINUS_CHAN_4  = 4'h1;

   // configuration word
   localparam int CFG_TWOS_BIT  = 10;
   localparam int CFG_PDIFF_BIT = 7;
   localparam logic [11:0] CFG_RESET = 12'h000;

   // serial clock made by the host
   localparam int SYS_PERIOD_NS  = 20;
   localparam int SCLK_PERIOD_NS = 320;
   localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * SYS_PERIOD_NS);
   localparam logic [2:0] HALF_LAST  = 3'(SCLK_HALF_CYC - 1);
   localparam logic [4:0] HALVES_LAST = 5'h1f;
endpackage

// ### asc_link_if.sv
// serial link between host and converter command port.
// assumes the host end reads sdo_line; the data out pin idles high when released.
`timescale 1ns/1ns
`default_nettype none
interface asc_link_if;
   logic sclk;
   logic cs_n;
   logic frame_sync_in;
   logic sdi;
   logic sdo;
   logic sdo_oe;
   logic sdo_line;

   // released pin pulled high
   assign sdo_line = sdo_oe ? sdo : 1'b1;

   modport dev  (input sclk, input cs_n, input frame_sync_in, input sdi,
                 output sdo, output sdo_oe);
   modport host (output sclk, output cs_n, output frame_sync_in, output sdi,
                 input sdo_line);
endinterface
`default_nettype wire

// ### asc_host.sv
// host end of the serial command port: makes the serial clock by division,
// sends one 16-bit word per frame and buffers the returned words.
// assumes the link partner is the converter end on the same interface.
`timescale 1ns/1ns
`default_nettype none
module asc_host (
   input  wire logic        sys_clk_i,
   input  wire logic        reset_i,
   asc_link_if.host         link,
   input  wire logic        cmd_valid_i,
   input  wire logic [15:0] cmd_word_i,
   input  wire logic        use_sync_i,
   output logic             cmd_ready_o,
   output logic             rx_valid_o,
   output logic      [15:0] rx_word_o,
   input  wire logic        rx_ready_i
);
   typedef enum logic [2:0] {H_IDLE, H_SEL, H_SYNC, H_SHIFT, H_END} asc_host_t;

   asc_host_t   state;
   logic [1:0]  sdo_sy;
   logic [2:0]  div;
   logic        tick;
   logic [4:0]  hcnt;
   logic [4:0]  next_hcnt;
   logic        sync_mode;
   logic [15:0] tx;
   logic [15:0] rx;
   logic        push;
   logic        pop;
   logic        tail_v;
   logic [15:0] tail_d;

   assign tick      = (div == asc_pkg::HALF_LAST);
   assign next_hcnt = hcnt + 5'h01;
   assign push      = (state == H_END) && tick;
   assign pop       = rx_valid_o && rx_ready_i;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         sdo_sy <= 2'h3;
      end else begin
         sdo_sy <= {sdo_sy[0], link.sdo_line};
      end
   end

   // half-period divider
   always_ff @(posedge sys_clk_i) begin
      if (reset_i || state == H_IDLE || tick) begin
         div <= 3'h0;
      end else begin
         div <= div + 3'h1;
      end
   end

   // frame sequencer
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         state              <= H_IDLE;
         link.sclk          <= 1'b0;
         link.cs_n          <= 1'b1;
         link.frame_sync_in <= 1'b1;
         link.sdi           <= 1'b0;
         sync_mode          <= 1'b0;
         hcnt               <= 5'h00;
         tx                 <= 16'h0000;
         rx                 <= 16'h0000;
      end else begin
         case (state)
            H_IDLE: begin
               if (cmd_valid_i && cmd_ready_o) begin
                  sync_mode          <= use_sync_i;
                  tx                 <= cmd_word_i;
                  link.sdi           <= cmd_word_i[15]; // see R3
                  link.sclk          <= use_sync_i;
                  link.cs_n          <= 1'b0;
                  link.frame_sync_in <= !use_sync_i; // see R9
                  state              <= H_SEL;
               end
            end
            H_SEL: begin
               if (tick) begin
                  hcnt <= 5'h00;
                  if (sync_mode) begin
                     link.frame_sync_in <= 1'b1;
                     state              <= H_SYNC;
                  end else begin
                     state <= H_SHIFT;
                  end
               end
            end
            H_SYNC: begin
               if (tick) begin
                  link.frame_sync_in <= 1'b0; // see R10
                  state              <= H_SHIFT;
               end
            end
            H_SHIFT: begin
               if (tick) begin
                  hcnt      <= next_hcnt;
                  link.sclk <= sync_mode ^ next_hcnt[0];
                  if (next_hcnt[0]) begin
                     rx <= {rx[14:0], sdo_sy[1]};
                  end else begin
                     tx       <= {tx[14:0], 1'b0};
                     link.sdi <= tx[14];
                  end
                  if (hcnt == asc_pkg::HALVES_LAST) begin
                     link.sclk <= sync_mode;
                     state     <= H_END;
                  end
               end
            end
            H_END: begin
               if (tick) begin
                  link.cs_n          <= 1'b1;
                  link.frame_sync_in <= 1'b1;
                  state              <= H_IDLE;
               end
            end
            default: state <= H_IDLE;
         endcase
      end
   end

   // command acceptance waits for a free buffer slot
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         cmd_ready_o <= 1'b0;
      end else begin
         cmd_ready_o <= (state == H_IDLE) && !tail_v && !(cmd_ready_o && cmd_valid_i);
      end
   end

   // two-entry receive buffer
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         rx_valid_o <= 1'b0;
         rx_word_o  <= 16'h0000;
         tail_v     <= 1'b0;
         tail_d     <= 16'h0000;
      end else if (pop) begin
         if (tail_v) begin
            rx_word_o <= tail_d;
            tail_v    <= push;
            tail_d    <= rx;
         end else if (push) begin
            rx_word_o <= rx;
         end else begin
            rx_valid_o <= 1'b0;
         end
      end else if (push) begin
         if (!rx_valid_o) begin
            rx_valid_o <= 1'b1;
            rx_word_o  <= rx;
         end else begin
            tail_v <= 1'b1;
            tail_d <= rx;
         end
      end
   end
endmodule // asc_host
`default_nettype wire

// ### asc_link_monitor.sv
// wire checks on the serial link joining the host and converter ends.
// assumes it sits beside the link interface, on the same system clock and reset.
`timescale 1ns/1ns
`default_nettype none
module asc_link_monitor (
   input  wire logic sys_clk_i,
   input  wire logic reset_i,
   input  wire logic sclk,
   input  wire logic cs_n,
   input  wire logic frame_sync_in,
   input  wire logic sdi,
   input  wire logic sdo,
   input  wire logic sdo_oe
);
   logic       sclk_q;
   logic       cs_n_q;
   logic [4:0] fall_cnt;

   default clocking mon_cb @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);

   always_ff @(posedge sys_clk_i) begin
      sclk_q <= sclk;
      cs_n_q <= cs_n;
   end

   // falling serial clock edges within the current frame
   always_ff @(posedge sys_clk_i) begin
      if (reset_i || cs_n) begin
         fall_cnt <= 5'h00;
      end else if (sclk_q && !sclk && !cs_n_q) begin
         fall_cnt <= fall_cnt + 5'h01;
      end
   end

   sequence spi_start_s;
      $fell(cs_n) && frame_sync_in;
   endsequence

   sequence sync_start_s;
      $fell(frame_sync_in) && !cs_n && !cs_n_q;
   endsequence

   spi_frame_start_a: assert property (spi_start_s |-> ##[1:8] sdo_oe)
      else $error("output not driven after select-style frame start");
   sync_frame_start_a: assert property (sync_start_s |-> ##[1:8] sdo_oe)
      else $error("output not driven after sync-style frame start");
   early_drive_a: assert property ($rose(sdo_oe) |-> !$past(cs_n, 2))
      else $error("output driven before the frame began");
   idle_release_a: assert property (cs_n [*5] |-> !sdo_oe)
      else $error("output driven while select is high");
   end_release_a: assert property ($rose(cs_n) |-> !$past(sdo_oe))
      else $error("output still driven after the last bit");
   frame_length_a: assert property ($rose(cs_n) |-> fall_cnt == 5'h10)
      else $error("frame did not carry sixteen bits");
   spi_in_stable_a: assert property (
      $rose(sclk) && !cs_n && frame_sync_in |-> $stable(sdi))
      else $error("input bit moved at its sampling edge");
   sync_in_stable_a: assert property (
      $fell(sclk) && !cs_n && !frame_sync_in |-> $stable(sdi))
      else $error("input bit moved at its sampling edge");
   spi_out_edge_a: assert property (
      sdo_oe && $past(sdo_oe) && $changed(sdo) && frame_sync_in |-> !sclk)
      else $error("output bit changed in the wrong clock phase");
   sync_out_edge_a: assert property (
      sdo_oe && $past(sdo_oe) && $changed(sdo) && !frame_sync_in |-> sclk)
      else $error("output bit changed in the wrong clock phase");
endmodule // asc_link_monitor
`default_nettype wire

// ### adc_serial_command_port_test.sv
// self-checking bench: host end and converter end joined by the link interface.
// assumes the host user side is driven here and result_i stands in for the converter.
`timescale 1ns/1ns
`default_nettype none
module adc_serial_command_port_test;
   logic        sys_clk_i, reset_i, cmd_valid_i, use_sync_i, rx_ready_i;
   logic        cmd_ready_o, rx_valid_o, mux_en_o, sample_start_o;
   logic        power_down_o, pseudo_diff_o, fifo_pop_o;
   logic [15:0] cmd_word_i, rx_word_o;
   logic [9:0]  result_i;
   logic [3:0]  mux_sel_o;
   logic [11:0] config_word_o;
   int          fail_count, comparisons, pop_count, start_count;

   asc_link_if link_if ();
   asc_device #(.EIGHT_INPUTS(1'b1)) i_asc_device (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .link(link_if), .result_i(result_i), .mux_sel_o(mux_sel_o), .mux_en_o(mux_en_o),
      .sample_start_o(sample_start_o), .power_down_o(power_down_o),
      .pseudo_diff_o(pseudo_diff_o), .fifo_pop_o(fifo_pop_o), .config_word_o(config_word_o));
   asc_host i_asc_host (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .link(link_if),
      .cmd_valid_i(cmd_valid_i), .cmd_word_i(cmd_word_i), .use_sync_i(use_sync_i),
      .cmd_ready_o(cmd_ready_o), .rx_valid_o(rx_valid_o), .rx_word_o(rx_word_o),
      .rx_ready_i(rx_ready_i));
   asc_link_monitor i_asc_link_monitor (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .sclk(link_if.sclk), .cs_n(link_if.cs_n), .frame_sync_in(link_if.frame_sync_in),
      .sdi(link_if.sdi), .sdo(link_if.sdo), .sdo_oe(link_if.sdo_oe));

   initial begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end

   always @(posedge sys_clk_i) begin
      if (fifo_pop_o === 1'b1) pop_count++;
      if (sample_start_o === 1'b1) start_count++;
   end

   task automatic results;
      if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] expected);
      comparisons++;
      if (seen !== expected) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, expected);
      end
   endtask

   task automatic issue(input logic [15:0] word, input logic sync);
      int n;
      n = 0;
      while (cmd_ready_o !== 1'b1 && n < 1000) begin
         @(negedge sys_clk_i);
         n++;
      end
      if (n == 1000) fail_count++;
      cmd_word_i  = word;
      use_sync_i  = sync;
      cmd_valid_i = 1'b1;
      @(negedge sys_clk_i);
      cmd_valid_i = 1'b0;
   endtask

   task automatic pop(output logic [15:0] word);
      int n;
      n = 0;
      while (rx_valid_o !== 1'b1 && n < 2000) begin
         @(negedge sys_clk_i);
         n++;
      end
      if (n == 2000) fail_count++;
      word       = rx_word_o;
      rx_ready_i = 1'b1;
      @(negedge sys_clk_i);
      rx_ready_i = 1'b0;
   endtask

   task automatic xfer(input logic [15:0] word, input logic sync, output logic [15:0] rx);
      issue(word, sync);
      pop(rx);
   endtask

   initial begin
      repeat (30000) @(posedge sys_clk_i);
      fail_count++;
      results();
   end

   initial begin
      logic [15:0] rx;
      int          i;
      cmd_valid_i = 1'b0;
      cmd_word_i  = 16'h0000;
      use_sync_i  = 1'b0;
      rx_ready_i  = 1'b0;
      result_i    = 10'h000;
      reset_i     = 1'b1;
      repeat (10) @(negedge sys_clk_i);
      reset_i = 1'b0;
      @(negedge sys_clk_i);
      check({15'h0000, mux_en_o}, 16'h0000);
      xfer(16'ha000, 1'b0, rx);
      check({4'h0, config_word_o}, 16'h0000);
      // every channel code, frame style alternating in pairs, boundary result codes
      for (i = 0; i < 8; i++) begin
         result_i = i[0] ? 10'h3ff : 10'h000;
         xfer({i[3:0], 12'h000}, i[1], rx);
         check(rx & 16'hffc0, {result_i, 6'h00});
         check({12'h000, mux_sel_o}, {12'h000, i[3:0]});
         check({15'h0000, mux_en_o}, 16'h0001);
         check(16'(start_count), 16'(i + 1));
      end
      for (i = 0; i < 3; i++) begin
         xfer({4'hb + i[3:0], 12'h000}, i[0], rx);
         check({12'h000, mux_sel_o}, {12'h000, asc_pkg::SEL_TEST_MID + i[3:0]});
         check(16'(start_count), 16'(i + 9));
      end
      result_i = 10'h2a5;
      xfer(16'he000, 1'b1, rx);
      check(rx & 16'hffc0, {10'h2a5, 6'h00});
      check(16'(pop_count), 16'h0001);
      check(16'(start_count), 16'h000b);
      xfer(16'h8000, 1'b0, rx);
      check({15'h0000, power_down_o}, 16'h0001);
      xfer(16'ha400, 1'b0, rx);
      check({4'h0, config_word_o}, 16'h0400);
      check({15'h0000, power_down_o}, 16'h0000);
      for (i = 0; i < 2; i++) begin
         xfer(16'h9abc, i[0], rx);
         check({4'h0, rx[11:0]}, 16'h0400);
         check({4'h0, config_word_o}, 16'h0400);
         result_i = i[0] ? 10'h3ff : 10'h000;
         xfer(16'h3abc, i[0], rx);
         check(rx & 16'hffc0, {i[0] ? 10'h1ff : 10'h200, 6'h00});
         check({12'h000, mux_sel_o}, 16'h0003);
      end
      xfer(16'hf5a5, 1'b0, rx);
      check({4'h0, config_word_o}, 16'h0400);
      check({12'h000, mux_sel_o}, 16'h0003);
      check(16'(start_count), 16'h000d);
      xfer(16'ha080, 1'b1, rx);
      check({15'h0000, pseudo_diff_o}, 16'h0001);
      xfer(16'h0000, 1'b0, rx);
      xfer(16'h2000, 1'b0, rx);
      check({12'h000, mux_sel_o}, 16'h0000);
      // consumer stalls: two words held, third request refused
      result_i = 10'h1c3;
      issue(16'h9000, 1'b0);
      issue(16'h4000, 1'b1);
      repeat (400) @(negedge sys_clk_i);
      check({15'h0000, cmd_ready_o}, 16'h0000);
      pop(rx);
      check({4'h0, rx[11:0]}, 16'h0080);
      pop(rx);
      check(rx & 16'hffc0, {10'h1c3, 6'h00});
      results();
   end
endmodule // adc_serial_command_port_test
`default_nettype wire
